// >>> cct_pkg.sv
// Shared constants, mode codes and carrier types of the multi-mode timer.
package cct_pkg;

  // Clock source select code for the system clock, also the reset value.
  localparam logic [2:0]  CCT_CLK_SYS      = 3'h0;

  // Mode field codes in timer and compare operation.
  localparam logic [3:0]  CCT_MODE_TIMER   = 4'h0;
  localparam logic [3:0]  CCT_OC_HIGH      = 4'h1;
  localparam logic [3:0]  CCT_OC_LOW       = 4'h2;
  localparam logic [3:0]  CCT_OC_TOGGLE    = 4'h3;
  localparam logic [3:0]  CCT_OC_DUAL      = 4'h4;
  localparam logic [3:0]  CCT_OC_DUAL_BUF  = 4'h5;
  localparam logic [3:0]  CCT_OC_CENTER    = 4'hF;

  // Mode field codes in capture operation.
  localparam logic [3:0]  CCT_IC_ANY       = 4'h0;
  localparam logic [3:0]  CCT_IC_RISE      = 4'h1;
  localparam logic [3:0]  CCT_IC_FALL      = 4'h2;
  localparam logic [3:0]  CCT_IC_BOTH      = 4'h3;
  localparam logic [3:0]  CCT_IC_RISE4     = 4'h4;
  localparam logic [3:0]  CCT_IC_RISE16    = 4'h5;

  // Prescaler terminal counts for every fourth and sixteenth edge.
  localparam logic [3:0]  CCT_PRE_LAST4    = 4'h3;
  localparam logic [3:0]  CCT_PRE_LAST16   = 4'hF;
  localparam logic [3:0]  CCT_PRE_RST      = 4'h0;

  // Counter limits and values after reset.
  localparam logic [15:0] CCT_CNT16_MAX    = 16'hFFFF;
  localparam logic [15:0] CCT_CNT16_RST    = 16'h0000;
  localparam logic [31:0] CCT_CNT32_RST    = 32'h0000_0000;

  // Major operating mode of the block.
  typedef enum logic [1:0] {
    CCT_IDLE    = 2'b00,
    CCT_TIMER   = 2'b01,
    CCT_COMPARE = 2'b10,
    CCT_CAPTURE = 2'b11
  } cct_major_e;

  // Configuration bits that software drives into the block.
  typedef struct packed {
    logic       enable;               // Block on.
    logic       capture_select;       // Capture operation.
    logic       wide_timer_select;    // 32-bit operation.
    logic [3:0] mode_field;           // Sub-mode code.
    logic [2:0] clock_source_select;  // Time base clock source.
    logic       trigger_enable;       // Trigger instead of sync.
    logic [4:0] sync_source_select;   // Sync or trigger input.
    logic       gate_enable;          // Timer mode gating.
  } cct_cfg_s;

endpackage : cct_pkg

// >>> cct_edge_sync.sv
// Two-stage input synchroniser with edge pulses for a group of pins.
`timescale 1ns/1ps
module cct_edge_sync
  import cct_pkg::*;
#(
  parameter int W = 1
)
(
  input  wire logic         clk_i,    // System clock.
  input  wire logic         rst_i,    // Synchronous reset, active high.
  input  wire logic [W-1:0] d_i,      // Asynchronous pins.
  output logic      [W-1:0] level_o,  // Synchronised level.
  output logic      [W-1:0] rise_o,   // One-cycle rising pulse.
  output logic      [W-1:0] fall_o    // One-cycle falling pulse.
);

  logic [W-1:0] meta_reg;
  logic [W-1:0] sync_reg;
  logic [W-1:0] last_reg;

  // The first stage is read only by the second, so metastability
  // never reaches the edge detector.
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      meta_reg <= '0;
      sync_reg <= '0;
      last_reg <= '0;
    end
    else
    begin
      meta_reg <= d_i;
      sync_reg <= meta_reg;
      last_reg <= sync_reg;
    end
  end

  // Edges compare the settled stage with its own delayed copy.
  assign level_o = sync_reg;
  assign rise_o  = sync_reg & ~last_reg;
  assign fall_o  = ~sync_reg & last_reg;

endmodule : cct_edge_sync

// >>> cct_timer.sv
// Multi-mode timer, output compare and input capture block.
`timescale 1ns/1ps
module cct_timer
  import cct_pkg::*;
(
  input  wire logic        clk_i,             // System clock, 100 MHz.
  input  wire logic        rst_i,             // Synchronous reset.
  input  wire cct_cfg_s    cfg_i,             // Configuration bits.
  input  wire logic [15:0] period_low_i,      // Primary period.
  input  wire logic [15:0] period_high_i,     // Secondary period.
  input  wire logic [31:0] compare_a_i,       // Primary compare value.
  input  wire logic [31:0] compare_b_i,       // Secondary compare value.
  input  wire logic        trigger_clear_i,   // Trigger clear pulse.
  input  wire logic [7:0]  clk_src_i,         // Clock pins, bit 0 unused.
  input  wire logic [31:0] sync_in_i,         // Sync or trigger inputs.
  input  wire logic        gate_i,            // Timer mode gate pin.
  input  wire logic        capture_pin_i,     // Capture input pin.
  output logic      [15:0] count_low_o,       // Low count, delayed.
  output logic      [15:0] count_high_o,      // High count, delayed.
  output logic             sync_out_o,        // Primary rollover pulse.
  output logic             compare_event_flag_o, // Event pulse.
  output logic             compare_out_o,     // Compare output pin.
  output logic             trigger_status_o,  // Trigger status level.
  output logic      [31:0] capture_buffer_o,  // Last captured value.
  output logic             capture_valid_o,   // Capture write pulse.
  output cct_major_e       major_mode_o       // Active major mode.
);

  cct_cfg_s    cfg_q;
  cct_major_e  mode_reg;
  cct_major_e  mode_next;
  logic [15:0] cnt_lo_reg;
  logic [15:0] cnt_hi_reg;
  logic [31:0] a_buf_reg;
  logic [31:0] b_buf_reg;
  logic [3:0]  pre_reg;
  logic [7:0]  clk_rise;
  logic [31:0] sync_rise;
  logic [1:0]  pin_level;
  logic [1:0]  pin_rise;
  logic [1:0]  pin_fall;
  logic        recfg;
  logic        wide;
  logic        timebase;
  logic        tick;
  logic        gate_ok;
  logic        sync_evt;
  logic        sync_clr;
  logic        clr_now;
  logic        hold;
  logic        run;
  logic        lo_wrap;
  logic        hi_wrap;
  logic        lo_full;
  logic [31:0] cnt32;
  logic [31:0] cmp_cnt;
  logic [31:0] a_eff;
  logic [31:0] b_eff;
  logic        match_a;
  logic        match_b;
  logic        cap_edge;
  logic        cap_evt;

  // Pin groups pass two flip-flops before any logic reads them.
  cct_edge_sync #(.W(8)) u_clk_sync (
    .clk_i   (clk_i),
    .rst_i   (rst_i),
    .d_i     (clk_src_i),
    .level_o (),
    .rise_o  (clk_rise),
    .fall_o  ()
  );

  cct_edge_sync #(.W(32)) u_sync_sync (
    .clk_i   (clk_i),
    .rst_i   (rst_i),
    .d_i     (sync_in_i),
    .level_o (),
    .rise_o  (sync_rise),
    .fall_o  ()
  );

  cct_edge_sync #(.W(2)) u_pin_sync (
    .clk_i   (clk_i),
    .rst_i   (rst_i),
    .d_i     ({capture_pin_i, gate_i}),
    .level_o (pin_level),
    .rise_o  (pin_rise),
    .fall_o  (pin_fall)
  );

  // Decode the single major mode; illegal combinations stay idle.
  always_comb
  begin
    mode_next = CCT_IDLE;
    if (!cfg_i.enable)
      mode_next = CCT_IDLE;
    else if (cfg_i.capture_select)
      mode_next = (cfg_i.mode_field <= CCT_IC_RISE16) ? CCT_CAPTURE
                                                       : CCT_IDLE;
    else if (cfg_i.mode_field == CCT_MODE_TIMER)
      mode_next = CCT_TIMER;
    else if (cfg_i.mode_field <= CCT_OC_TOGGLE)
      mode_next = CCT_COMPARE;
    else if ((cfg_i.mode_field == CCT_OC_DUAL ||
              cfg_i.mode_field == CCT_OC_DUAL_BUF ||
              cfg_i.mode_field == CCT_OC_CENTER) &&
             !cfg_i.wide_timer_select)
      mode_next = CCT_COMPARE;
    else
      mode_next = CCT_IDLE;
  end

  // Any change of mode bits is a reconfiguration and restarts state.
  assign recfg = {cfg_i.enable, cfg_i.capture_select,
                  cfg_i.wide_timer_select, cfg_i.mode_field} !=
                 {cfg_q.enable, cfg_q.capture_select,
                  cfg_q.wide_timer_select, cfg_q.mode_field};

  // Registered view of the configuration and the major mode.
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      cfg_q    <= '0;
      mode_reg <= CCT_IDLE;
    end
    else
    begin
      cfg_q    <= cfg_i;
      mode_reg <= mode_next;
    end
  end

  // Time base enable: the system clock ticks every cycle, other
  // sources tick on their synchronised rising edge.
  assign wide     = cfg_q.wide_timer_select;
  assign timebase = (mode_reg == CCT_TIMER) || (mode_reg == CCT_COMPARE);
  assign gate_ok  = !cfg_q.gate_enable || pin_level[0];
  assign tick     = (mode_reg != CCT_IDLE) &&
                    ((cfg_q.clock_source_select == CCT_CLK_SYS) ? 1'b1 :
                     clk_rise[cfg_q.clock_source_select]) &&
                    ((mode_reg != CCT_TIMER) || gate_ok);

  // Sync clears, trigger holds; set wins over clear on the status.
  assign sync_evt = sync_rise[cfg_q.sync_source_select];
  assign sync_clr = timebase && sync_evt && !cfg_q.trigger_enable;
  assign clr_now  = cfg_q.trigger_enable && trigger_clear_i && !sync_evt;
  assign hold     = timebase && cfg_q.trigger_enable &&
                    (!trigger_status_o || clr_now);
  assign run      = tick && !hold && !sync_clr;
  assign cnt32    = {cnt_hi_reg, cnt_lo_reg};
  assign lo_full  = cnt_lo_reg == CCT_CNT16_MAX;
  assign lo_wrap  = run && (wide ? (cnt32 == {period_high_i, period_low_i})
                                 : (cnt_lo_reg == period_low_i));
  assign hi_wrap  = tick && !wide && (mode_reg == CCT_TIMER) &&
                    (cnt_hi_reg == period_high_i);

  // Trigger status follows the selected input and the clear request.
  always_ff @(posedge clk_i)
  begin
    if (rst_i || !cfg_q.trigger_enable || !timebase)
      trigger_status_o <= 1'b0;
    else if (sync_evt)
      trigger_status_o <= 1'b1;
    else if (trigger_clear_i)
      trigger_status_o <= 1'b0;
  end

  // Low counter: primary time base, or capture timer in capture mode.
  always_ff @(posedge clk_i)
  begin
    if (rst_i || recfg)
      cnt_lo_reg <= CCT_CNT16_RST;
    else if (mode_reg == CCT_CAPTURE)
    begin
      if (tick)
        cnt_lo_reg <= cnt_lo_reg + 16'h1;
    end
    else if (hold || sync_clr)
      cnt_lo_reg <= CCT_CNT16_RST;
    else if (lo_wrap)
      cnt_lo_reg <= CCT_CNT16_RST;
    else if (run)
      cnt_lo_reg <= cnt_lo_reg + 16'h1;
  end

  // High counter: carry half in wide mode, secondary timer in dual.
  // The secondary ignores sync and trigger so its period stays steady.
  always_ff @(posedge clk_i)
  begin
    if (rst_i || recfg)
      cnt_hi_reg <= CCT_CNT16_RST;
    else if (wide)
    begin
      if (mode_reg == CCT_CAPTURE)
      begin
        if (tick && lo_full)
          cnt_hi_reg <= cnt_hi_reg + 16'h1;
      end
      else if (hold || sync_clr || lo_wrap)
        cnt_hi_reg <= CCT_CNT16_RST;
      else if (run && lo_full)
        cnt_hi_reg <= cnt_hi_reg + 16'h1;
    end
    else if (hi_wrap)
      cnt_hi_reg <= CCT_CNT16_RST;
    else if (tick && mode_reg == CCT_TIMER)
      cnt_hi_reg <= cnt_hi_reg + 16'h1;
  end

  // Compare values load every cycle, or only at rollover when buffered
  // so that a PWM duty change never splits a period.
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      a_buf_reg <= CCT_CNT32_RST;
      b_buf_reg <= CCT_CNT32_RST;
    end
    else if (cfg_q.mode_field != CCT_OC_DUAL_BUF ||
             mode_reg != CCT_COMPARE || lo_wrap)
    begin
      a_buf_reg <= compare_a_i;
      b_buf_reg <= compare_b_i;
    end
  end

  // Matches use the full 32 bits only in wide operation.
  assign cmp_cnt = wide ? cnt32 : {16'h0000, cnt_lo_reg};
  assign a_eff   = wide ? a_buf_reg : {16'h0000, a_buf_reg[15:0]};
  assign b_eff   = wide ? b_buf_reg : {16'h0000, b_buf_reg[15:0]};
  assign match_a = (mode_reg == CCT_COMPARE) && run &&
                   (cmp_cnt == a_eff);
  assign match_b = (mode_reg == CCT_COMPARE) && run &&
                   (cmp_cnt == b_eff) &&
                   (cfg_q.mode_field >= CCT_OC_DUAL);

  // Output compare pin; a dual edge with both matches together ends low.
  always_ff @(posedge clk_i)
  begin
    if (rst_i || recfg || mode_reg != CCT_COMPARE)
      compare_out_o <= 1'b0;
    else
    begin
      case (cfg_q.mode_field)
        CCT_OC_HIGH:
          if (match_a)
            compare_out_o <= 1'b1;
        CCT_OC_LOW:
          if (match_a)
            compare_out_o <= 1'b0;
        CCT_OC_TOGGLE:
          if (match_a)
            compare_out_o <= ~compare_out_o;
        CCT_OC_DUAL, CCT_OC_DUAL_BUF:
          if (match_b)
            compare_out_o <= 1'b0;
          else if (match_a)
            compare_out_o <= 1'b1;
        CCT_OC_CENTER:
          compare_out_o <= (cnt_lo_reg >= a_buf_reg[15:0]) &&
                           (cnt_lo_reg < b_buf_reg[15:0]);
        default:
          compare_out_o <= compare_out_o;
      endcase
    end
  end

  // Capture edge selection.
  always_comb
  begin
    case (cfg_q.mode_field)
      CCT_IC_ANY, CCT_IC_BOTH:
        cap_edge = pin_rise[1] | pin_fall[1];
      CCT_IC_RISE, CCT_IC_RISE4, CCT_IC_RISE16:
        cap_edge = pin_rise[1];
      CCT_IC_FALL:
        cap_edge = pin_fall[1];
      default:
        cap_edge = 1'b0;
    endcase
  end

  // Edge prescaler for the divided capture modes.
  always_ff @(posedge clk_i)
  begin
    if (rst_i || recfg)
      pre_reg <= CCT_PRE_RST;
    else if (mode_reg == CCT_CAPTURE && pin_rise[1])
      pre_reg <= pre_reg + 4'h1;
  end

  assign cap_evt = (mode_reg == CCT_CAPTURE) && cap_edge &&
                   ((cfg_q.mode_field == CCT_IC_RISE4) ?
                      (pre_reg[1:0] == CCT_PRE_LAST4[1:0]) :
                    (cfg_q.mode_field == CCT_IC_RISE16) ?
                      (pre_reg == CCT_PRE_LAST16) : 1'b1);

  // Capture store, events and delayed count view.
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      capture_buffer_o     <= CCT_CNT32_RST;
      capture_valid_o      <= 1'b0;
      compare_event_flag_o <= 1'b0;
      sync_out_o           <= 1'b0;
      count_low_o          <= CCT_CNT16_RST;
      count_high_o         <= CCT_CNT16_RST;
      major_mode_o         <= CCT_IDLE;
    end
    else
    begin
      if (cap_evt)
        capture_buffer_o <= cmp_cnt;
      capture_valid_o      <= cap_evt;
      compare_event_flag_o <= ((mode_reg == CCT_TIMER) &&
                               (wide ? lo_wrap : hi_wrap)) ||
                              match_a || match_b || cap_evt;
      sync_out_o           <= timebase && lo_wrap;
      count_low_o          <= cnt_lo_reg;
      count_high_o         <= cnt_hi_reg;
      major_mode_o         <= mode_reg;
    end
  end

  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);

  chk_mode_restart: assert property (
    recfg |=> (cnt_lo_reg == 16'h0) && (cnt_hi_reg == 16'h0))
    else $error("Counters not cleared after reconfiguration.");

  chk_sys_clock_tick: assert property (
    (cfg_q.clock_source_select == CCT_CLK_SYS) &&
    (mode_reg == CCT_CAPTURE) && !recfg && !lo_full
    |=> cnt_lo_reg == $past(cnt_lo_reg) + 16'h1)
    else $error("System clock source did not advance the count.");

  chk_dual_wrap: assert property (
    (mode_reg == CCT_TIMER) && !wide && run && !recfg &&
    (cnt_lo_reg == period_low_i) |=> cnt_lo_reg == 16'h0)
    else $error("Primary counter did not wrap at its period.");

  chk_high_event: assert property (
    hi_wrap |=> compare_event_flag_o)
    else $error("High period match raised no compare event.");

  chk_high_no_sync: assert property (
    hi_wrap && !lo_wrap |=> !sync_out_o)
    else $error("Secondary counter produced a sync output.");

  chk_wide_carry: assert property (
    (mode_reg == CCT_TIMER) && wide && run && lo_full && !lo_wrap &&
    !recfg |=> cnt_hi_reg == $past(cnt_hi_reg) + 16'h1)
    else $error("Low overflow did not carry into the high half.");

  chk_sync_clear: assert property (
    sync_clr && !recfg |=> cnt_lo_reg == 16'h0 ##1
    (!tick || hold || sync_clr || cnt_lo_reg == 16'h1 || lo_wrap))
    else $error("Sync input did not clear and restart the timer.");

  chk_trig_hold: assert property (
    (timebase && cfg_q.trigger_enable && !trigger_status_o &&
     !sync_evt) [*2] |-> cnt_lo_reg == 16'h0)
    else $error("Timer ran without a trigger.");

  chk_trig_clear: assert property (
    timebase && clr_now && !recfg |=> !trigger_status_o &&
    cnt_lo_reg == 16'h0)
    else $error("Trigger clear did not stop the timer.");

  chk_gate_capture: assert property (
    (mode_reg == CCT_CAPTURE) && cfg_q.gate_enable && !pin_level[0] &&
    (cfg_q.clock_source_select == CCT_CLK_SYS) |-> tick)
    else $error("Gating affected capture operation.");

  chk_cmp_high: assert property (
    match_a && (cfg_q.mode_field == CCT_OC_HIGH) && !recfg
    |=> compare_out_o)
    else $error("Output not driven high on compare match.");

  chk_cmp_toggle: assert property (
    match_a && (cfg_q.mode_field == CCT_OC_TOGGLE) && !recfg
    |=> compare_out_o != $past(compare_out_o))
    else $error("Output did not toggle on compare match.");

  chk_cap_store: assert property (
    cap_evt |=> capture_valid_o && (capture_buffer_o == $past(cmp_cnt)))
    else $error("Capture event did not store the count.");

  chk_cap_div4: assert property (
    cap_evt && (cfg_q.mode_field == CCT_IC_RISE4)
    |-> pre_reg[1:0] == 2'h3)
    else $error("Divide by four capture on wrong edge.");

  cov_sync_clear: cover property (sync_clr ##1 tick);
  cov_capture: cover property (cap_evt ##1 capture_valid_o);
  cov_toggle: cover property (match_a && cfg_q.mode_field == CCT_OC_TOGGLE);
  cov_trig_start: cover property (!trigger_status_o ##1 trigger_status_o);

endmodule : cct_timer

// >>> cct_pins.sv
// Pin-side model: sync, trigger and capture pins of the timer.
`timescale 1ns/1ps
module cct_pins
(
  input  wire logic        clk_i,   // System clock.
  output logic      [31:0] sync_o,  // Sync and trigger pins.
  output logic             cap_o    // Capture pin.
);
  // Pins idle low; each edge is launched just after a clock edge.
  initial
  begin
    sync_o = 32'h0000_0000;
    cap_o  = 1'b0;
  end

  // Hold a sync pin high long enough to cross the pin synchroniser.
  task automatic sync_pulse(input int sel);
    @(posedge clk_i);
    #1 sync_o[sel] = 1'b1;
    repeat (4) @(posedge clk_i);
    #1 sync_o[sel] = 1'b0;
  endtask : sync_pulse

  // Square pulses, four cycles high, rising edges eight cycles apart.
  task automatic cap_train(input int n);
    repeat (n)
    begin
      @(posedge clk_i);
      #1 cap_o = 1'b1;
      repeat (4) @(posedge clk_i);
      #1 cap_o = 1'b0;
      repeat (3) @(posedge clk_i);
    end
  endtask : cap_train
endmodule : cct_pins

// >>> cct_timer_tb.sv
// Self-checking bench of the multi-mode timer block.
`timescale 1ns/1ps
module cct_timer_tb;
  import cct_pkg::*;
  logic        clk_i = 1'b0;
  logic        rst_i = 1'b1;
  cct_cfg_s    cfg = '0;
  logic [15:0] per_lo = 16'h0000;
  logic [15:0] per_hi = 16'h0000;
  logic [31:0] cmp_a = 32'h0000_0000;
  logic [31:0] cmp_b = 32'h0000_0000;
  logic        trg_clr = 1'b0;
  logic [31:0] sync_pins;
  logic        cap_pin;
  logic [15:0] cnt_lo;
  logic [15:0] cnt_hi;
  logic        sync_out, evt, cmp_out, trg_st, cap_vld;
  logic [31:0] cap_buf;
  cct_major_e  major;
  logic [1:0]  sel = 2'h0;
  logic [7:0]  clk_src = 8'h00;
  logic        gate = 1'b1;
  logic        pick;
  logic [31:0] last_buf = 32'h0;
  logic [31:0] cap_gap = 32'h0;
  int          bad_count = 0;
  int          compares = 0;

  // System clock, 10 ns period.
  always #5 clk_i = ~clk_i;

  // Clock source pins and the gate pin are driven by the gate scenario.
  cct_timer dut_u (.clk_i(clk_i), .rst_i(rst_i), .cfg_i(cfg),
    .period_low_i(per_lo), .period_high_i(per_hi),
    .compare_a_i(cmp_a), .compare_b_i(cmp_b),
    .trigger_clear_i(trg_clr), .clk_src_i(clk_src),
    .sync_in_i(sync_pins), .gate_i(gate), .capture_pin_i(cap_pin),
    .count_low_o(cnt_lo), .count_high_o(cnt_hi), .sync_out_o(sync_out),
    .compare_event_flag_o(evt), .compare_out_o(cmp_out),
    .trigger_status_o(trg_st), .capture_buffer_o(cap_buf),
    .capture_valid_o(cap_vld), .major_mode_o(major));
  cct_pins pins_u (.clk_i(clk_i), .sync_o(sync_pins), .cap_o(cap_pin));

  // One selectable pulse output, so one counting task serves all.
  assign pick = (sel == 2'h0) ? sync_out : (sel == 2'h1) ? evt :
                (sel == 2'h2) ? cmp_out : cap_vld;

  // Spacing of the last two captures, kept for the value check.
  always @(posedge clk_i)
  begin
    if (cap_vld === 1'b1)
    begin
      cap_gap = cap_buf - last_buf;
      last_buf = cap_buf;
    end
  end

  task automatic tick(input int n = 1);
    repeat (n) @(posedge clk_i);
    #1;
  endtask : tick

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp)
    begin
      bad_count++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check

  // Count the cycles in which the chosen output is high.
  task automatic count(input logic [1:0] s, input int len, output int n);
    sel = s;
    n = 0;
    repeat (len)
    begin
      tick();
      n += (pick === 1'b1);
    end
  endtask : count

  // Always the system clock, so trigger use stays legal.
  task automatic setup(input logic cap, input logic wide,
                       input logic [3:0] mode, input logic trg);
    cct_major_e exp;
    exp = cap ? CCT_CAPTURE :
          (mode == CCT_MODE_TIMER) ? CCT_TIMER : CCT_COMPARE;
    cfg = '{enable: 1'b1, capture_select: cap, wide_timer_select: wide,
            mode_field: mode, clock_source_select: CCT_CLK_SYS,
            trigger_enable: trg, sync_source_select: 5'h03,
            gate_enable: 1'b0};
    tick(4);
    check(major, exp);
  endtask : setup

  task automatic t_dual;
    int n;
    logic [15:0] prev;
    per_lo = 16'h0002;
    per_hi = 16'h0004;
    setup(1'b0, 1'b0, CCT_MODE_TIMER, 1'b0);
    count(2'h0, 30, n);
    check(n, 10);
    count(2'h1, 30, n);
    check(n, 6);
    prev = cnt_lo;
    repeat (6)
    begin
      tick();
      check(cnt_lo, (prev == per_lo) ? 16'h0000 : prev + 16'h0001);
      prev = cnt_lo;
    end
    per_lo = 16'hFFFF;
    count(2'h0, 40, n);
    check(n, 0);
    count(2'h1, 40, n);
    check(n, 8);
    $display("test dual timer done");
  endtask : t_dual

  task automatic t_wide;
    int n;
    setup(1'b0, 1'b1, CCT_MODE_TIMER, 1'b0);
    per_hi = 16'h0001;
    per_lo = 16'h0003;
    for (n = 0; n < 70000 && cnt_hi !== 16'h0001; n++)
      tick();
    check(cnt_lo, 16'h0000);
    count(2'h0, 8, n);
    check(n, 1);
    $display("test wide timer done");
  endtask : t_wide

  task automatic t_sync;
    per_lo = 16'hFFFF;
    setup(1'b0, 1'b0, CCT_MODE_TIMER, 1'b0);
    tick(30);
    check(cnt_lo > 16'd20, 1'b1);
    pins_u.sync_pulse(3);
    check(cnt_lo < 16'd8, 1'b1);
    $display("test sync done");
  endtask : t_sync

  task automatic t_trig;
    setup(1'b0, 1'b0, CCT_MODE_TIMER, 1'b1);
    tick(10);
    check(cnt_lo, 16'h0000);
    check(trg_st, 1'b0);
    pins_u.sync_pulse(3);
    tick(10);
    check(trg_st, 1'b1);
    check(cnt_lo > 16'd8, 1'b1);
    trg_clr = 1'b1;
    tick();
    trg_clr = 1'b0;
    tick(3);
    check(trg_st, 1'b0);
    tick(10);
    check(cnt_lo, 16'h0000);
    $display("test trigger done");
  endtask : t_trig

  task automatic t_cmp;
    logic [3:0] modes [6] = '{CCT_OC_HIGH, CCT_OC_LOW, CCT_OC_TOGGLE,
                              CCT_OC_DUAL, CCT_OC_DUAL_BUF, CCT_OC_CENTER};
    int highs [6] = '{40, 0, 20, 16, 16, 16};
    int evts [6] = '{4, 4, 4, 8, 8, 8};
    int n;
    per_lo = 16'h0009;
    cmp_a = 32'h0000_0002;
    cmp_b = 32'h0000_0006;
    for (int i = 0; i < 6; i++)
    begin
      setup(1'b0, 1'b0, modes[i], 1'b0);
      tick(12);
      count(2'h2, 40, n);
      check(n, highs[i]);
      count(2'h1, 40, n);
      check(n, evts[i]);
    end
    $display("test compare done");
  endtask : t_cmp

  task automatic t_cap;
    int caps [6] = '{32, 16, 16, 32, 4, 1};
    int n;
    for (int i = 0; i < 6; i++)
    begin
      setup(1'b1, 1'b0, i[3:0], 1'b0);
      fork
        pins_u.cap_train(16);
        count(2'h3, 140, n);
      join
      check(n, caps[i]);
      if (i == 1)
        check(cap_gap, 32'h0000_0008);
    end
    $display("test capture done");
  endtask : t_cap

  // A pin clock source, then gating in timer and in capture operation.
  task automatic t_gate;
    logic [15:0] first;
    per_lo = 16'hFFFF;
    setup(1'b0, 1'b0, CCT_MODE_TIMER, 1'b0);
    cfg.clock_source_select = 3'h2;
    tick(2);
    first = cnt_lo;
    repeat (10)
    begin
      clk_src = 8'h04;
      tick(2);
      clk_src = 8'h00;
      tick(2);
    end
    tick(4);
    check(16'(cnt_lo - first), 16'h000A);
    cfg.clock_source_select = CCT_CLK_SYS;
    cfg.gate_enable = 1'b1;
    gate = 1'b0;
    tick(4);
    first = cnt_lo;
    tick(10);
    check(cnt_lo, first);
    setup(1'b1, 1'b0, CCT_IC_RISE, 1'b0);
    cfg.gate_enable = 1'b1;
    tick(2);
    first = cnt_lo;
    tick(10);
    check(16'(cnt_lo - first), 16'h000A);
    gate = 1'b1;
    $display("test clock source and gate done");
  endtask : t_gate

  task automatic end_of_test;
    $display("compares=%0d bad_count=%0d", compares, bad_count);
    if (bad_count == 0 && compares > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : end_of_test

  // Main sequence after three cycles of reset.
  initial
  begin
    tick(3);
    rst_i = 1'b0;
    tick();
    t_dual();
    t_wide();
    t_sync();
    t_trig();
    t_cmp();
    t_cap();
    t_gate();
    end_of_test();
  end

  // The run needs about 68k cycles; stop a hang at 90k cycles.
  initial
  begin
    #900_000;
    bad_count++;
    end_of_test();
  end
endmodule : cct_timer_tb
